// File: core/adrc_pkg.sv
// Package with register map, field positions and decode constants for the converter control.
package adrc_pkg;
  // ---------------------------------------------------------------
  // Register offsets and widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int SAMP_W = 16;
  localparam logic [12:0] OFS_SERVO_CTRL = 13'h000F;
  localparam logic [12:0] OFS_REF_SELECT = 13'h0018;
  localparam logic [12:0] OFS_DITHER_EN = 13'h0030;
  localparam logic [12:0] OFS_DITHER_GAIN = 13'h0212;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int SERVO_EN_BIT = 0;
  localparam int DITHER_EN_BIT = 4;
  localparam int CH_B_DITHER_BIT = 5;
  localparam int GAIN_LSB = 4;
  localparam int REF_SEL_MSB = 2;
  localparam logic [7:0] SERVO_RST = 8'h00;
  localparam logic [7:0] REF_RST = 8'h00;
  localparam logic [7:0] DITHER_EN_RST = 8'h00;
  localparam logic [7:0] DITHER_GAIN_RST = 8'h00;
  localparam logic [15:0] LFSR_SEED_A = 16'hACE1;
  localparam logic [15:0] LFSR_SEED_B = 16'h5B3D;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam int DITHER_W = 8;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ADRC_IDLE = 2'b00, ADRC_ADDR = 2'b01, ADRC_DATA = 2'b11} adrc_spi_type;
  // Dither gain in 256ths: full, 255..192, then half scale; other codes clamp to half.
  function automatic logic [8:0] adrc_gain(input logic [3:0] code);
    unique case (code)
      4'h0: adrc_gain = 9'h100;
      4'h1: adrc_gain = 9'h0FF;
      4'h2: adrc_gain = 9'h0FE;
      4'h3: adrc_gain = 9'h0FC;
      4'h4: adrc_gain = 9'h0F8;
      4'h5: adrc_gain = 9'h0F0;
      4'h6: adrc_gain = 9'h0E0;
      4'h7: adrc_gain = 9'h0C0;
      default: adrc_gain = 9'h080;
    endcase
  endfunction
  // Scaled dither value that is injected and later removed.
  function automatic logic [15:0] adrc_scale(input logic [7:0] pn, input logic [8:0] g);
    logic [16:0] prod;
    prod = {8'h00, pn} * {8'h00, g};
    adrc_scale = {8'h00, prod[15:8]};
  endfunction
endpackage

// File: core/adrc_lfsr.sv
// Pseudorandom source for one channel's dither path.
`timescale 1ns/1ps
`default_nettype none
module adrc_lfsr
  import adrc_pkg::*;
#(
  parameter logic [15:0] SEED = 16'hACE1
)(
  input wire logic clk_sys, // sample clock
  input wire logic sys_rst, // async reset, active high
  input wire logic advance, // step once this cycle
  output logic [7:0] pn_value // registered random code
);
  logic [15:0] state_r;
  wire [15:0] state_nxt = state_r[0] ? ((state_r >> 1) ^ LFSR_TAPS) : (state_r >> 1);

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_r <= SEED;
    else if (advance)
      state_r <= state_nxt;
  end

  assign pn_value = state_r[7:0];
endmodule
`default_nettype wire

// File: core/adrc_ctrl.sv
// Converter control: serial register port, dither paths, servo channel pick, reference select.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - With both channels running, the servo watches channel A's input.
// - If channel A is powered down or in standby and channel B is not, the servo watches channel B.
// - Servo mode is on only while bit 0 of the register at 0x0F is high.
// - Each channel has its own dither enable.
// - While dither is on, the dither DAC code comes from the pseudorandom source.
// - The injected dither times the gain is subtracted from the sample before output.
// - Channel A dither is on only while bit 4 of register dither_enable_control is set; channel B uses bit 5.
// - Dither amplitude comes from bits 7 to 4 of register dither_gain_control.
// - Gain codes: 0 full, 1..7 are 255..192 of 256, 8 is half scale.
// - Internal reference voltage comes from register reference_voltage_select, reset gives 1.25 V.
// - Reference pin low selects internal reference; at supply level, external is used.
module adrc_ctrl
  import adrc_pkg::*;
(
  input wire logic clk_sys, // sample clock
  input wire logic sys_rst, // async reset, active high
  input wire logic spi_sclk, // serial clock pin
  input wire logic spi_csb_n, // serial chip select, active low
  input wire logic spi_sdio_in, // serial data pin level
  output logic spi_sdio_out, // serial read data
  output logic spi_sdio_oe_n, // low while the block drives the data pin
  input wire logic [adrc_pkg::SAMP_W-1:0] raw_a, // digitized sample A with dither
  input wire logic [adrc_pkg::SAMP_W-1:0] raw_b, // digitized sample B with dither
  input wire logic ch_a_down, // channel A in power-down or standby
  input wire logic ch_b_down, // channel B in power-down or standby
  input wire logic sense_pin, // reference mode pin, high at analog_supply_level
  output logic [adrc_pkg::SAMP_W-1:0] out_a, // corrected sample A
  output logic [adrc_pkg::SAMP_W-1:0] out_b, // corrected sample B
  output logic [adrc_pkg::DITHER_W-1:0] dac_a, // dither DAC code A
  output logic [adrc_pkg::DITHER_W-1:0] dac_b, // dither DAC code B
  output logic servo_active, // common_mode_output servo running
  output logic servo_sel_b, // servo watches channel B
  output logic int_ref_en, // internal reference enabled
  output logic [2:0] ref_select // reference voltage code
);
  import adrc_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Pins are two-flop synchronised; the sample clock must exceed four times sclk.
  logic [1:0] sclk_s_r, csb_s_r, sdi_s_r, sense_s_r;
  logic sclk_d_r;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sclk_s_r <= 2'h0;
      csb_s_r <= 2'h3;
      sdi_s_r <= 2'h0;
      sense_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      sclk_s_r <= {sclk_s_r[0], spi_sclk};
      csb_s_r <= {csb_s_r[0], spi_csb_n};
      sdi_s_r <= {sdi_s_r[0], spi_sdio_in};
      sense_s_r <= {sense_s_r[0], sense_pin};
      sclk_d_r <= sclk_s_r[1];
    end
  end
  wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
  wire csb_act = ~csb_s_r[1];

  // ---------------------------------------------------------------
  // Serial frame: R/W bit, 2 length bits, 13 address bits, 8 data bits
  // ---------------------------------------------------------------
  adrc_spi_type st_r, st_nxt;
  logic [4:0] cnt_r;
  logic [15:0] hdr_r;
  logic [7:0] wsh_r, rsh_r;
  logic [7:0] servo_r, ref_r, den_r, dgain_r;
  logic rd_r;

  wire [12:0] frame_addr = hdr_r[12:0];
  wire hdr_done = (st_r == ADRC_ADDR) && sclk_rise && (cnt_r == 5'd15);
  wire byte_done = (st_r == ADRC_DATA) && sclk_rise && (cnt_r == 5'd7);
  wire [7:0] wbyte = {wsh_r[6:0], sdi_s_r[1]};
  wire wr_go = byte_done && !rd_r;
  wire [12:0] hdr_addr = {hdr_r[11:0], sdi_s_r[1]};
  wire [7:0] rd_mux = (hdr_addr == OFS_SERVO_CTRL) ? servo_r :
                      (hdr_addr == OFS_REF_SELECT) ? ref_r :
                      (hdr_addr == OFS_DITHER_EN) ? den_r :
                      (hdr_addr == OFS_DITHER_GAIN) ? dgain_r : 8'h00;

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      ADRC_IDLE: if (csb_act) st_nxt = ADRC_ADDR;
      ADRC_ADDR: if (hdr_done) st_nxt = ADRC_DATA;
      ADRC_DATA: st_nxt = ADRC_DATA;
      default: st_nxt = ADRC_IDLE;
    endcase
    if (!csb_act)
      st_nxt = ADRC_IDLE;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= ADRC_IDLE;
      cnt_r <= 5'd0;
      hdr_r <= 16'h0000;
      wsh_r <= 8'h00;
      rd_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (!csb_act || hdr_done || byte_done)
        cnt_r <= 5'd0;
      else if (sclk_rise && st_r != ADRC_IDLE)
        cnt_r <= cnt_r + 5'd1;
      if (!csb_act)
        rd_r <= 1'b0;
      else if (st_r == ADRC_ADDR && sclk_rise && cnt_r == 5'd0)
        rd_r <= sdi_s_r[1];
      if (st_r == ADRC_ADDR && sclk_rise)
        hdr_r <= {hdr_r[14:0], sdi_s_r[1]};
      else if (byte_done)
        hdr_r <= {hdr_r[15:13], frame_addr + 13'h0001};
      if (st_r == ADRC_DATA && sclk_rise)
        wsh_r <= wbyte;
    end
  end

  // Read data shifts out on falling sclk so the master samples it on the rising edge.
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rsh_r <= 8'h00;
    else if (hdr_done)
      rsh_r <= rd_mux;
    else if (st_r == ADRC_DATA && sclk_fall && cnt_r != 5'd0)
      rsh_r <= {rsh_r[6:0], 1'b0};
  end
  assign spi_sdio_out = rsh_r[7];
  assign spi_sdio_oe_n = !(rd_r && st_r == ADRC_DATA);

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      servo_r <= SERVO_RST;
      ref_r <= REF_RST;
      den_r <= DITHER_EN_RST;
      dgain_r <= DITHER_GAIN_RST;
    end
    else if (wr_go)
    begin
      if (frame_addr == OFS_SERVO_CTRL) servo_r <= wbyte;
      if (frame_addr == OFS_REF_SELECT) ref_r <= wbyte;
      if (frame_addr == OFS_DITHER_EN) den_r <= wbyte;
      if (frame_addr == OFS_DITHER_GAIN) dgain_r <= wbyte;
    end
  end

  // ---------------------------------------------------------------
  // Servo, reference and dither control
  // ---------------------------------------------------------------
  assign servo_active = servo_r[SERVO_EN_BIT];
  assign servo_sel_b = ch_a_down && !ch_b_down;
  assign int_ref_en = !sense_s_r[1];
  assign ref_select = ref_r[REF_SEL_MSB:0];

  // Channel B has its own enable bit; A follows the documented bit 4.
  wire dith_a = den_r[DITHER_EN_BIT];
  wire dith_b = den_r[CH_B_DITHER_BIT];
  wire [8:0] gain = adrc_gain(dgain_r[7:GAIN_LSB]);
  wire [7:0] pn_a, pn_b;

  adrc_lfsr #(.SEED(LFSR_SEED_A)) u_pn_a (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .advance(dith_a),
    .pn_value(pn_a)
  );
  adrc_lfsr #(.SEED(LFSR_SEED_B)) u_pn_b (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .advance(dith_b),
    .pn_value(pn_b)
  );

  // The DAC code and the subtracted value come from the same registered sample,
  // so the analog path is assumed to return the dithered sample in the same cycle the DAC code is shown.
  logic [15:0] inj_a_r, inj_b_r;
  wire [15:0] scl_a = dith_a ? adrc_scale(pn_a, gain) : 16'h0000;
  wire [15:0] scl_b = dith_b ? adrc_scale(pn_b, gain) : 16'h0000;
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dac_a <= 8'h00;
      dac_b <= 8'h00;
      inj_a_r <= 16'h0000;
      inj_b_r <= 16'h0000;
      out_a <= 16'h0000;
      out_b <= 16'h0000;
    end
    else
    begin
      dac_a <= scl_a[7:0];
      dac_b <= scl_b[7:0];
      inj_a_r <= scl_a;
      inj_b_r <= scl_b;
      out_a <= raw_a - inj_a_r;
      out_b <= raw_b - inj_b_r;
    end
  end
endmodule
`default_nettype wire

// File: tb/adrc_ctrl_sva.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adrc_ctrl_chk (
  input wire logic clk_sys, // clock
  input wire logic sys_rst, // reset
  input wire logic spi_csb_n, // select
  input wire logic spi_sdio_oe_n, // drive enable
  input wire logic [15:0] raw_a, // raw A
  input wire logic [15:0] raw_b, // raw B
  input wire logic ch_a_down, // A down
  input wire logic ch_b_down, // B down
  input wire logic sense_pin, // ref pin
  input wire logic [15:0] out_a, // out A
  input wire logic [15:0] out_b, // out B
  input wire logic [7:0] dac_a, // dac A
  input wire logic [7:0] dac_b, // dac B
  input wire logic servo_active, // servo on
  input wire logic servo_sel_b, // servo on B
  input wire logic int_ref_en, // internal ref
  input wire logic [2:0] ref_select // ref code
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  property p_sel_a; !ch_a_down |-> !servo_sel_b; endproperty
  a_sel_a: assert property (p_sel_a) else $error("servo left channel A");
  property p_sel_b; ch_a_down && !ch_b_down |-> servo_sel_b; endproperty
  a_sel_b: assert property (p_sel_b) else $error("servo not on channel B");
  property p_out_a; !$past(sys_rst) |-> out_a == $past(raw_a) - {8'h00, $past(dac_a)}; endproperty
  a_out_a: assert property (p_out_a) else $error("dither not removed on A");
  property p_out_b; !$past(sys_rst) |-> out_b == $past(raw_b) - {8'h00, $past(dac_b)}; endproperty
  a_out_b: assert property (p_out_b) else $error("dither not removed on B");
  // The two-flop pin synchroniser needs three quiet samples before the output must follow.
  property p_ref_pin;
    !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3) && $past(sense_pin) == sense_pin
      && $past(sense_pin, 2) == sense_pin |-> int_ref_en == !sense_pin;
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference mode wrong");
  property p_oe_idle; spi_csb_n [*4] |-> spi_sdio_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data pin driven while idle");
  property p_ref_hold; spi_csb_n [*6] |=> $stable(ref_select); endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("reference code moved");
  property p_servo_hold; spi_csb_n [*6] |=> $stable(servo_active); endproperty
  a_servo_hold: assert property (p_servo_hold) else $error("servo mode moved");
  c_sel_b: cover property (servo_sel_b && servo_active);
  c_dith: cover property (dac_a != 8'h00 && dac_b != 8'h00);
  c_read: cover property (!spi_sdio_oe_n);
endmodule
`default_nettype wire

// File: tb/adrc_ctrl_tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adrc_ctrl_tb;
  import adrc_pkg::*;
  logic clk_sys, sys_rst, spi_sclk, spi_csb_n, spi_sdio_in, ch_a_down, ch_b_down, sense_pin;
  logic spi_sdio_out, spi_sdio_oe_n, servo_active, servo_sel_b, int_ref_en;
  logic [15:0] raw_a, raw_b, out_a, out_b;
  logic [7:0] dac_a, dac_b, rd;
  logic [2:0] ref_select;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  adrc_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n),
    .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe_n(spi_sdio_oe_n),
    .raw_a(raw_a), .raw_b(raw_b), .ch_a_down(ch_a_down), .ch_b_down(ch_b_down),
    .sense_pin(sense_pin), .out_a(out_a), .out_b(out_b), .dac_a(dac_a), .dac_b(dac_b),
    .servo_active(servo_active), .servo_sel_b(servo_sel_b), .int_ref_en(int_ref_en),
    .ref_select(ref_select));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Each serial clock level is held five cycles so the synchroniser always sees it.
  task automatic spi(input logic r, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {r, 2'b00, a, d};
    spi_csb_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    for (int i = 23; i >= 0; i--)
    begin
      spi_sdio_in <= f[i];
      spi_sclk <= 1'b0;
      repeat (5) @(posedge clk_sys);
      spi_sclk <= 1'b1;
      repeat (5) @(posedge clk_sys);
      if (i < 8) q[i] = spi_sdio_out;
    end
    spi_sclk <= 1'b0;
    repeat (5) @(posedge clk_sys);
    spi_csb_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    spi(1'b0, a, d, rd);
  endtask
  task automatic run(output logic [7:0] ma, output logic [7:0] mb, output int c);
    logic [15:0] ea, eb;
    logic [7:0] pa, pb;
    ma = 8'h00;
    mb = 8'h00;
    pa = 8'h00;
    pb = 8'h00;
    c = 0;
    @(posedge clk_sys);
    for (int i = 0; i < 200; i++)
    begin
      ea = raw_a - {8'h00, dac_a};
      eb = raw_b - {8'h00, dac_b};
      if (dac_a > ma) ma = dac_a;
      if (dac_b > mb) mb = dac_b;
      raw_a <= raw_a + 16'h0137;
      raw_b <= raw_b - 16'h0459;
      @(posedge clk_sys);
      chk(out_a, ea);
      chk(out_b, eb);
      // A fresh dither value per sample shows as a new code on both channels.
      if (dac_a != pa && dac_b != pb) c++;
      pa = dac_a;
      pb = dac_b;
    end
  endtask
  task automatic t_regs();
    logic [12:0] adr [4] = '{13'h000F, 13'h0018, 13'h0030, 13'h0212};
    for (int k = 0; k < 4; k++)
    begin
      spi(1'b1, adr[k], 8'h00, rd);
      chk(rd, 8'h00);
    end
    chk(ref_select, 3'h0);
    chk(int_ref_en, 1'b1);
    chk(servo_active, 1'b0);
    wr(13'h0018, 8'h05);
    spi(1'b1, 13'h0018, 8'h00, rd);
    chk(rd, 8'h05);
    chk(ref_select, 3'h5);
    wr(13'h000F, 8'hFE);
    chk(servo_active, 1'b0);
    wr(13'h000F, 8'h01);
    chk(servo_active, 1'b1);
    wr(13'h0100, 8'h5A);
    chk(ref_select, 3'h5);
    spi(1'b1, 13'h0100, 8'h00, rd);
    chk(rd, 8'h00);
  endtask
  task automatic t_pins();
    for (int i = 0; i < 4; i++)
    begin
      {ch_a_down, ch_b_down} <= i[1:0];
      repeat (2) @(posedge clk_sys);
      chk(servo_sel_b, i == 2);
    end
    sense_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(int_ref_en, 1'b0);
    sense_pin <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(int_ref_en, 1'b1);
  endtask
  task automatic t_dith();
    logic [7:0] ma, mb;
    int c;
    logic [7:0] en [4] = '{8'h00, 8'h10, 8'h20, 8'hEF};
    logic [8:0] g [10] = '{9'h100, 9'h0FF, 9'h0FE, 9'h0FC, 9'h0F8, 9'h0F0, 9'h0E0, 9'h0C0, 9'h080,
      9'h080};
    for (int k = 0; k < 4; k++)
    begin
      wr(13'h0030, en[k]);
      run(ma, mb, c);
      chk(ma != 8'h00, k == 1);
      chk(mb != 8'h00, k > 1);
    end
    wr(13'h0030, 8'h30);
    // Code 9 lies above the documented table and is expected to clamp to half scale.
    for (int k = 0; k < 10; k++)
    begin
      wr(13'h0212, {k[3:0], 4'h0});
      run(ma, mb, c);
      chk(ma <= (255 * g[k]) >> 8 && ma + 16 > (255 * g[k]) >> 8, 1'b1);
      chk(mb <= (255 * g[k]) >> 8, 1'b1);
      chk(c > 150, 1'b1);
    end
  endtask
  initial
  begin
    {sys_rst, spi_csb_n, spi_sclk, spi_sdio_in, ch_a_down, ch_b_down, sense_pin} = 7'h60;
    raw_a = 16'h1234;
    raw_b = 16'hFEDC;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_regs();
    t_pins();
    t_dith();
    report_and_stop();
  end
endmodule
bind adrc_ctrl adrc_ctrl_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .spi_csb_n(spi_csb_n),
  .spi_sdio_oe_n(spi_sdio_oe_n), .raw_a(raw_a), .raw_b(raw_b), .ch_a_down(ch_a_down),
  .ch_b_down(ch_b_down), .sense_pin(sense_pin), .out_a(out_a), .out_b(out_b), .dac_a(dac_a),
  .dac_b(dac_b), .servo_active(servo_active), .servo_sel_b(servo_sel_b),
  .int_ref_en(int_ref_en), .ref_select(ref_select));
`default_nettype wire
